// ===== verilog/lfl_fault_supervisor.sv
`timescale 1ns/1ps
module lfl_fault_supervisor (
    input wire logic clk, // System clock, 50 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic scl_pin, // Serial clock from the microcontroller.
    input wire logic sda_in, // Serial data pin level.
    output logic sda_out, // Serial data drive value.
    output logic sda_oe, // Serial data pull-down enable.
    input wire logic bias_monitor_pin, // Bias comparator, high above reference.
    input wire logic photodiode_monitor_pin, // Photodiode comparator, high above reference.
    input wire logic shutdown_input_pin, // Disable pin, high disables.
    input wire logic [9:0] meas_bias_code, // Measured bias current.
    input wire logic [9:0] meas_pd_code, // Measured photodiode current.
    input wire logic [9:0] meas_temp_code, // Temperature sensor sample.
    input wire logic [9:0] meas_supply_code, // Supply monitor sample.
    input wire logic conv_done, // Converter sample ready, one cycle.
    output logic fault_output, // Latched fault, high on fault.
    output logic [7:0] bias_current_code, // Bias current drive.
    output logic [7:0] mod_current_code // Modulation current drive.
);
    lfl_reg_if rbus ();
    logic [7:0] ctrl_reg, bias_dac_reg, mod_dac_reg, pd_set_reg;
    logic [7:0] mon_cfg_reg, bias_thr_reg, pd_thr_reg, adc_cfg_reg;
    logic [7:0] res_hi_reg, res_lo_reg;
    logic bt_m, bt_s, pt_m, pt_s, shut_m, shut_s;
    logic bias_hit, pd_hit, pd_over, fault_any_reg, dac_drop_reg, fault_latch_reg;
    logic disabled, fen, out_on, active_c;
    logic [9:0] conv_mux;
    logic [7:0] negate_cnt_reg;

    lfl_serial_slave u_serial (
        .clk(clk),
        .rst_n(rst_n),
        .scl_pin(scl_pin),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(rbus.serial)
    );

    // Comparator and disable pins arrive unsynchronised.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bt_m <= 1'b0;
            bt_s <= 1'b0;
            pt_m <= 1'b0;
            pt_s <= 1'b0;
            shut_m <= 1'b1;
            shut_s <= 1'b1;
        end else begin
            bt_m <= bias_monitor_pin;
            bt_s <= bt_m;
            pt_m <= photodiode_monitor_pin;
            pt_s <= pt_m;
            shut_m <= shutdown_input_pin;
            shut_s <= shut_m;
        end
    end

    // Writable registers; the result registers ignore writes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= lfl_pkg::CTRL_RST;
            bias_dac_reg <= lfl_pkg::ZERO_RST;
            mod_dac_reg <= lfl_pkg::ZERO_RST;
            pd_set_reg <= lfl_pkg::ZERO_RST;
            mon_cfg_reg <= lfl_pkg::ZERO_RST;
            bias_thr_reg <= lfl_pkg::ZERO_RST;
            pd_thr_reg <= lfl_pkg::ZERO_RST;
            adc_cfg_reg <= lfl_pkg::ZERO_RST;
        end else if (rbus.wr) begin
            unique case (rbus.addr)
                lfl_pkg::ADDR_CTRL: ctrl_reg <= rbus.wdata;
                lfl_pkg::ADDR_BIAS: bias_dac_reg <= rbus.wdata;
                lfl_pkg::ADDR_MOD: mod_dac_reg <= rbus.wdata;
                lfl_pkg::ADDR_PDSET: pd_set_reg <= rbus.wdata;
                lfl_pkg::ADDR_MONCFG: mon_cfg_reg <= rbus.wdata;
                lfl_pkg::ADDR_BTHR: bias_thr_reg <= rbus.wdata;
                lfl_pkg::ADDR_PTHR: pd_thr_reg <= rbus.wdata;
                lfl_pkg::ADDR_ADCCFG: adc_cfg_reg <= rbus.wdata;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped indices read as zero.
    always_comb begin
        unique case (rbus.addr)
            lfl_pkg::ADDR_CTRL: rbus.rdata = ctrl_reg;
            lfl_pkg::ADDR_BIAS: rbus.rdata = bias_dac_reg;
            lfl_pkg::ADDR_MOD: rbus.rdata = mod_dac_reg;
            lfl_pkg::ADDR_PDSET: rbus.rdata = pd_set_reg;
            lfl_pkg::ADDR_STATUS: rbus.rdata = {4'h0, dac_drop_reg, pd_hit, bias_hit, fault_latch_reg};
            lfl_pkg::ADDR_MONCFG: rbus.rdata = mon_cfg_reg;
            lfl_pkg::ADDR_BTHR: rbus.rdata = bias_thr_reg;
            lfl_pkg::ADDR_PTHR: rbus.rdata = pd_thr_reg;
            lfl_pkg::ADDR_ADCCFG: rbus.rdata = adc_cfg_reg;
            lfl_pkg::ADDR_RES_HI: rbus.rdata = res_hi_reg;
            lfl_pkg::ADDR_RES_LO: rbus.rdata = res_lo_reg;
            default: rbus.rdata = 8'h00;
        endcase
    end

    // Converter source selection.
    always_comb begin
        unique case (lfl_pkg::lfl_sel_t'(adc_cfg_reg[1:0]))
            lfl_pkg::SEL_TEMP: conv_mux = meas_temp_code;
            lfl_pkg::SEL_SUPPLY: conv_mux = meas_supply_code;
            lfl_pkg::SEL_PD: conv_mux = meas_pd_code;
            lfl_pkg::SEL_BIAS: conv_mux = meas_bias_code;
        endcase
    end

    // Both result halves load together so a high/low read pair is coherent between samples.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_hi_reg <= 8'h00;
            res_lo_reg <= 8'h00;
        end else if (conv_done && !adc_cfg_reg[lfl_pkg::ADC_OFF_BIT]) begin
            res_hi_reg <= conv_mux[9:2];
            res_lo_reg <= {6'h00, conv_mux[1:0]};
        end
    end

    // Fault sources; the digital path takes over from the comparator when selected.
    assign bias_hit = mon_cfg_reg[lfl_pkg::MON_DB_BIT] ? (meas_bias_code[9:2] > bias_thr_reg) : bt_s;
    assign pd_hit = mon_cfg_reg[lfl_pkg::MON_DP_BIT] ? (meas_pd_code[9:2] > pd_thr_reg)
        : (pt_s && mon_cfg_reg[lfl_pkg::MON_PTRIG_BIT]);
    // Two times the measurement against three times the set value avoids a divider.
    assign pd_over = {1'b0, meas_pd_code[9:2], 1'b0} > ({2'b00, pd_set_reg} + {1'b0, pd_set_reg, 1'b0});
    assign fen = ctrl_reg[lfl_pkg::CTRL_FEN_BIT];
    assign out_on = ctrl_reg[lfl_pkg::CTRL_ON_BIT];
    assign disabled = shut_s || !out_on;

    // A bias write that more than halves the old value is a one-shot fault event.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_drop_reg <= 1'b0;
        end else begin
            dac_drop_reg <= rbus.wr && rbus.addr == lfl_pkg::ADDR_BIAS
                && {1'b0, rbus.wdata, 1'b0} < {2'b00, bias_dac_reg};
        end
    end

    // Registered fault summary.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_any_reg <= 1'b0;
        end else begin
            fault_any_reg <= bias_hit || pd_hit || pd_over || dac_drop_reg;
        end
    end

    // Fault latch: cleared while disabled, set again on release if the fault persists.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_latch_reg <= 1'b0;
        end else if (disabled) begin
            fault_latch_reg <= 1'b0;
        end else if (fault_any_reg && fen) begin
            fault_latch_reg <= 1'b1;
        end
    end

    // Disable negate timer, restarted on every disabled cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            negate_cnt_reg <= lfl_pkg::NEGATE_CYC;
        end else if (disabled) begin
            negate_cnt_reg <= lfl_pkg::NEGATE_CYC;
        end else if (negate_cnt_reg != 8'h00) begin
            negate_cnt_reg <= negate_cnt_reg - 8'h01;
        end
    end

    // Settings survive in the DAC registers, so recovery brings them back once the negate timer reaches zero.
    assign active_c = !disabled && negate_cnt_reg == 8'h00 && !fault_latch_reg && !(fault_any_reg && fen);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bias_current_code <= 8'h00;
            mod_current_code <= 8'h00;
        end else begin
            bias_current_code <= active_c ? bias_dac_reg : 8'h00;
            mod_current_code <= active_c ? mod_dac_reg : 8'h00;
        end
    end

    assign fault_output = fault_latch_reg;

    sequence s_release;
        $fell(disabled);
    endsequence

    AST_RESULT_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        conv_done && !adc_cfg_reg[lfl_pkg::ADC_OFF_BIT] |=> {res_hi_reg, res_lo_reg[1:0]} == $past(conv_mux))
        else $error("Converter result was not captured.");
    AST_BIAS_DIG: assert property (@(posedge clk) disable iff (!rst_n)
        mon_cfg_reg[lfl_pkg::MON_DB_BIT] && meas_bias_code[9:2] > bias_thr_reg |=> fault_any_reg)
        else $error("Digital bias fault missed.");
    AST_PD_ANALOG: assert property (@(posedge clk) disable iff (!rst_n)
        !mon_cfg_reg[lfl_pkg::MON_DP_BIT] && mon_cfg_reg[lfl_pkg::MON_PTRIG_BIT] && pt_s |=> fault_any_reg)
        else $error("Photodiode comparator fault missed.");
    AST_PD_OVER: assert property (@(posedge clk) disable iff (!rst_n)
        2 * meas_pd_code[9:2] > 3 * pd_set_reg |=> fault_any_reg)
        else $error("Photodiode overcurrent fault missed.");
    AST_DAC_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        rbus.wr && rbus.addr == lfl_pkg::ADDR_BIAS && 2 * rbus.wdata < bias_dac_reg |=> ##1 fault_any_reg)
        else $error("Bias DAC drop fault missed.");
    AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rst_n)
        fault_any_reg && fen && !disabled |=> fault_output && bias_current_code == 8'h00 && mod_current_code == 8'h00)
        else $error("Fault did not shut the outputs down.");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        disabled |=> !fault_output && bias_current_code == 8'h00)
        else $error("Fault output stayed set while disabled.");
    AST_NEGATE: assert property (@(posedge clk) disable iff (!rst_n)
        s_release |-> bias_current_code == 8'h00 ##1 bias_current_code == 8'h00)
        else $error("Outputs resumed before the negate time.");
    AST_REASSERT: assert property (@(posedge clk) disable iff (!rst_n)
        s_release and fault_any_reg && fen |=> fault_output)
        else $error("Persistent fault did not reassert on release.");
    AST_NO_EN: assert property (@(posedge clk) disable iff (!rst_n)
        !fen && !fault_latch_reg |=> !fault_output)
        else $error("Fault latched with shutdown disabled.");
endmodule // lfl_fault_supervisor

// ===== verilog/lfl_pkg.sv
package lfl_pkg;
    // Register indices on the serial management link.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BIAS = 4'h1;
    localparam logic [3:0] ADDR_MOD = 4'h2;
    localparam logic [3:0] ADDR_PDSET = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MONCFG = 4'ha;
    localparam logic [3:0] ADDR_BTHR = 4'hb;
    localparam logic [3:0] ADDR_PTHR = 4'hc;
    localparam logic [3:0] ADDR_ADCCFG = 4'hd;
    localparam logic [3:0] ADDR_RES_HI = 4'he;
    localparam logic [3:0] ADDR_RES_LO = 4'hf;
    // Field positions.
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_FEN_BIT = 1;
    localparam int MON_DB_BIT = 0;
    localparam int MON_DP_BIT = 1;
    localparam int MON_PTRIG_BIT = 2;
    localparam int ADC_OFF_BIT = 7;
    // Reset values: fault shutdown armed, output off until software enables it.
    localparam logic [7:0] CTRL_RST = 8'h02;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // Serial device address; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h48;
    // Disable negate time, a least time, rounded up to clock cycles.
    localparam int CLK_PERIOD_NS = 20;
    localparam int NEGATE_NS = 1000;
    localparam logic [7:0] NEGATE_CYC = 8'((NEGATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Converter input select codes.
    typedef enum logic [1:0] {
        SEL_TEMP = 2'h0,
        SEL_SUPPLY = 2'h1,
        SEL_PD = 2'h2,
        SEL_BIAS = 2'h3
    } lfl_sel_t;
endpackage

// ===== verilog/lfl_reg_if.sv
`timescale 1ns/1ps
interface lfl_reg_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport serial (output addr, output wdata, output wr, input rdata);
    modport regs (input addr, input wdata, input wr, output rdata);
endinterface

// ===== verilog/lfl_serial_slave.sv
`timescale 1ns/1ps
module lfl_serial_slave (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic scl_pin, // Serial clock pin.
    input wire logic sda_in, // Serial data pin level.
    output logic sda_out, // Serial data drive value.
    output logic sda_oe, // Serial data pull-down enable.
    lfl_reg_if.serial bus // Register access toward the register file.
);
    typedef enum {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD} lfl_ser_st_t;
    lfl_ser_st_t state_reg;
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg;
    logic [3:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wr_reg;
    logic start_c, stop_c, rise_c, fall_c;

    // Two-stage synchronisers plus a delay stage; the edge logic compares the second stage with the third.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_pin;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Bus conditions seen from the sampled lines.
    assign start_c = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c = scl_s && scl_d && !sda_d && sda_s;
    assign rise_c = scl_s && !scl_d;
    assign fall_c = !scl_s && scl_d;

    // Byte engine: address, pointer, write bytes and read bytes with auto-increment.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_reg <= 4'h0;
            wdata_reg <= 8'h00;
            wr_reg <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (wr_reg) begin
                addr_reg <= addr_reg + 4'h1;
            end
            if (start_c) begin
                state_reg <= ST_DEV;
                bit_cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_reg <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (rise_c && state_reg != ST_IDLE) begin
                bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
                if (bit_cnt_reg != 4'h8) begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                end else if (state_reg == ST_RD && sda_s) begin
                    state_reg <= ST_IDLE; // Master refused the byte: read ends.
                end
            end else if (fall_c && state_reg != ST_IDLE) begin
                if (bit_cnt_reg == 4'h8) begin
                    sda_oe <= state_reg != ST_RD;
                    unique case (state_reg)
                        ST_DEV: begin
                            if (shift_reg[7:1] == lfl_pkg::DEV_ADDR) begin
                                state_reg <= shift_reg[0] ? ST_RD : ST_PTR;
                            end else begin
                                state_reg <= ST_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end
                        ST_PTR: begin
                            addr_reg <= shift_reg[3:0];
                            state_reg <= ST_WR;
                        end
                        ST_WR: begin
                            wdata_reg <= shift_reg;
                            wr_reg <= 1'b1;
                        end
                        ST_RD: addr_reg <= addr_reg + 4'h1;
                        ST_IDLE: sda_oe <= 1'b0;
                    endcase
                end else if (state_reg == ST_RD) begin
                    // Read data is taken fresh at each byte so status is never stale.
                    if (bit_cnt_reg == 4'h0) begin
                        sda_oe <= !bus.rdata[7];
                        tx_reg <= {bus.rdata[6:0], 1'b0};
                    end else begin
                        sda_oe <= !tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // The pin is open drain: it only ever pulls low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
    assign bus.wr = wr_reg;

    AST_PTR_INC: assert property (@(posedge clk) disable iff (!rst_n) wr_reg |=> addr_reg == $past(addr_reg) + 4'h1)
        else $error("Register pointer did not advance after a write.");
endmodule // lfl_serial_slave

// ===== sim/lfl_host_model.sv
`timescale 1ns/1ps
// Microcontroller on the two-wire link; its clock idles high and only toggles inside frames.
module lfl_host_model (
    input wire logic clk, // System clock that paces the link.
    input wire logic sda_wire, // Resolved data line, pulled up when released.
    output logic scl_pin, // Serial clock to the device.
    output logic sda_low // High while the host pulls data low.
);
    // Idle bus: both lines released.
    initial begin
        scl_pin = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data moves one cycle after the clock fall, so it never passes for a start or stop.
    // Four cycles low and four high make a 160 ns bit.
    task automatic bit_io(input logic b, output logic seen);
        tick(1);
        sda_low = !b;
        tick(3);
        scl_pin = 1'b1;
        tick(4);
        seen = sda_wire;
        scl_pin = 1'b0;
    endtask
    // Start, or repeated start when the clock is low.
    task automatic start_cond();
        tick(1);
        sda_low = 1'b0;
        tick(4);
        scl_pin = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl_pin = 1'b0;
    endtask
    task automatic stop_cond();
        tick(1);
        sda_low = 1'b1;
        tick(4);
        scl_pin = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    // Eight bits MSB first, then the acknowledge slot.
    task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, a);
    endtask
    // One register write, or a read that ends with a release of the last acknowledge.
    task automatic xfer(input logic rd, input logic [3:0] r, input logic [7:0] wd, output logic [7:0] q,
                        output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        byte_io({lfl_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io({4'h0, r}, 1'b1, q, a1);
        if (rd) begin
            start_cond();
            byte_io({lfl_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a2);
            a0 |= a2;
        end
        byte_io(wd, 1'b1, q, a2);
        stop_cond();
        ok = !(a0 | a1) & (a2 == rd);
    endtask
endmodule // lfl_host_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, scl_pin, sda_low, sda_out, sda_oe, sda_wire, ok;
    logic bias_pin, pd_pin, shut_pin, conv_done, fault_output;
    logic [9:0] mb, mp, mt, ms, code;
    logic [7:0] bias_code, mod_code, rd, bias_set, mod_set, thr;
    logic [31:0] rnd;
    int bad_count, samples_checked;
    // Open-drain data line: low if either party pulls, else the pull-up wins.
    assign sda_wire = !(sda_low || (sda_oe && !sda_out));
    // 50 MHz system clock.
    initial clk = 1'b0;
    always #10 clk = ~clk;
    lfl_fault_supervisor dut (
        .clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .bias_monitor_pin(bias_pin), .photodiode_monitor_pin(pd_pin), .shutdown_input_pin(shut_pin),
        .meas_bias_code(mb), .meas_pd_code(mp), .meas_temp_code(mt), .meas_supply_code(ms),
        .conv_done(conv_done), .fault_output(fault_output), .bias_current_code(bias_code),
        .mod_current_code(mod_code)
    );
    lfl_host_model host (.clk(clk), .sda_wire(sda_wire), .scl_pin(scl_pin), .sda_low(sda_low));
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    // Sample the converter should hold for an input select code.
    function automatic logic [9:0] pick(input logic [1:0] s);
        case (s)
            2'h0: return mt;
            2'h1: return ms;
            2'h2: return mp;
            default: return mb;
        endcase
    endfunction
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] r, input logic [7:0] d);
        host.xfer(1'b0, r, d, rd, ok);
        check(17'(ok), 17'h1);
    endtask
    task automatic rchk(input logic [3:0] r, input logic [7:0] e);
        host.xfer(1'b1, r, 8'hff, rd, ok);
        check({8'h0, ok, rd}, {9'h1, e});
    endtask
    // Waits, bounded, for the latch and both drives to reach the expected state.
    task automatic settle(input logic f, input int n);
        int i;
        logic [16:0] want;
        want = f ? 17'h10000 : {1'b0, bias_set, mod_set};
        step(n);
        for (i = 0; i < 80 && {fault_output, bias_code, mod_code} !== want; i++) step(1);
        check({fault_output, bias_code, mod_code}, want);
        // A wait that ran out has already counted its mismatch, so the run stops here.
        if ({fault_output, bias_code, mod_code} !== want) begin
            complete_run();
        end
    endtask
    task automatic recover_pin();
        shut_pin = 1'b1;
        step(6);
        check(17'(fault_output), 17'h0);
        shut_pin = 1'b0;
        // Drives must stay off for the whole negate time; the check lands two cycles short of NEGATE_CYC after the pin falls.
        step(int'(lfl_pkg::NEGATE_CYC) - 2);
        check({1'b0, bias_code, mod_code}, 17'h0);
    endtask
    task automatic recover_bit();
        wreg(lfl_pkg::ADDR_CTRL, 8'h02);
        check(17'(fault_output), 17'h0);
        wreg(lfl_pkg::ADDR_CTRL, 8'h03);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence: every wait inside is bounded, so the run always reaches the report.
    initial begin
        rst_n = 1'b0;
        {bias_pin, pd_pin, shut_pin, conv_done} = 4'h0;
        {mb, mp, mt, ms} = 40'h0;
        rnd = 32'h5ef9;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step(3);
        rchk(lfl_pkg::ADDR_CTRL, lfl_pkg::CTRL_RST);
        rchk(lfl_pkg::ADDR_RES_HI, 8'h00);
        rchk(4'h5, 8'h00);
        bias_set = 8'(xs()) | 8'h80;
        mod_set = 8'(xs());
        wreg(lfl_pkg::ADDR_BIAS, bias_set);
        wreg(lfl_pkg::ADDR_MOD, mod_set);
        wreg(lfl_pkg::ADDR_PDSET, 8'hff);
        wreg(lfl_pkg::ADDR_CTRL, 8'h03);
        settle(1'b0, 0);
        // Every converter source; the high set-point keeps random photodiode samples harmless.
        for (int s = 0; s < 4; s++) begin
            {mb, mp, mt, ms} = {xs(), 8'(xs())};
            wreg(lfl_pkg::ADDR_ADCCFG, 8'(s));
            conv_done = 1'b1;
            step(1);
            conv_done = 1'b0;
            code = pick(2'(s));
            rchk(lfl_pkg::ADDR_RES_HI, code[9:2]);
            rchk(lfl_pkg::ADDR_RES_LO, {6'h0, code[1:0]});
        end
        host.xfer(1'b0, lfl_pkg::ADDR_RES_LO, 8'hff, rd, ok);
        rchk(lfl_pkg::ADDR_RES_LO, {6'h0, code[1:0]});
        // Converter switched off: a sample strobe must leave the held result alone.
        wreg(lfl_pkg::ADDR_ADCCFG, 8'h83);
        mb = ~code;
        conv_done = 1'b1;
        step(1);
        conv_done = 1'b0;
        rchk(lfl_pkg::ADDR_RES_HI, code[9:2]);
        {mb, mp} = 20'h0;
        // Analog bias fault, kept present across a disable pulse.
        bias_pin = 1'b1;
        settle(1'b1, 0);
        rchk(lfl_pkg::ADDR_STATUS, 8'h03);
        recover_pin();
        settle(1'b1, 0);
        bias_pin = 1'b0;
        recover_pin();
        settle(1'b0, 0);
        // Analog photodiode trip counts only once its trigger is enabled.
        pd_pin = 1'b1;
        settle(1'b0, 10);
        wreg(lfl_pkg::ADDR_MONCFG, 8'h04);
        settle(1'b1, 0);
        pd_pin = 1'b0;
        recover_bit();
        settle(1'b0, 0);
        // Digital bias path: the comparator is ignored, a value equal to the threshold is not a fault.
        wreg(lfl_pkg::ADDR_MONCFG, 8'h01);
        wreg(lfl_pkg::ADDR_BTHR, 8'h40);
        bias_pin = 1'b1;
        mb = {8'h40, 2'h3};
        settle(1'b0, 10);
        mb = {8'h41, 2'h0};
        settle(1'b1, 0);
        {mb, bias_pin} = 11'h0;
        recover_pin();
        settle(1'b0, 0);
        // Digital photodiode threshold, then the 150 percent limit, each at its boundary.
        for (int k = 0; k < 2; k++) begin
            thr = k ? 8'h60 : 8'h20;
            wreg(lfl_pkg::ADDR_MONCFG, k ? 8'h00 : 8'h02);
            wreg(k ? lfl_pkg::ADDR_PDSET : lfl_pkg::ADDR_PTHR, k ? 8'h40 : thr);
            mp = {thr, 2'h3};
            settle(1'b0, 10);
            mp = {thr + 8'h01, 2'h0};
            settle(1'b1, 0);
            mp = 10'h0;
            recover_pin();
            settle(1'b0, 0);
        end
        // Bias step to exactly half is allowed, below half trips.
        wreg(lfl_pkg::ADDR_BIAS, 8'h80);
        wreg(lfl_pkg::ADDR_BIAS, 8'h40);
        bias_set = 8'h40;
        settle(1'b0, 10);
        wreg(lfl_pkg::ADDR_BIAS, 8'h1f);
        settle(1'b1, 0);
        bias_set = 8'h1f;
        recover_bit();
        settle(1'b0, 0);
        // Shutdown disabled: a fault leaves drives and latch alone.
        wreg(lfl_pkg::ADDR_CTRL, 8'h01);
        bias_pin = 1'b1;
        settle(1'b0, 10);
        bias_pin = 1'b0;
        complete_run();
    end
endmodule // tb_top
